// file: src/shift_reg_cfg.svh
`ifndef SHIFT_REG_CFG_SVH
`define SHIFT_REG_CFG_SVH

// ****************************************************************
// Register geometry
// ****************************************************************
`define SR_STAGES      4
`define SR_STAGE_RESET 4'h0
`define SR_LAST_RESET  1'h1

// ****************************************************************
// Queued operation word layout
// ****************************************************************
`define SR_OP_WIDTH    7
`define SR_OP_PE_BIT   6
`define SR_OP_J_BIT    5
`define SR_OP_KN_BIT   4
`define SR_OP_LOAD_MSB 3
`define SR_OP_LOAD_LSB 0

// ****************************************************************
// Queue and synchroniser
// ****************************************************************
`define SR_FIFO_DEPTH  16
`define SR_SYNC_RESET  2'h0
`define SR_EDGE_RESET  1'h0
`define SR_PULSE_RESET 1'h0

`endif

// file: src/shift_reg_pkg.sv
package shift_reg_pkg;

  // First stage serial entry behaviour, one-hot
  typedef enum logic [3:0] {
    ENTRY_LOW    = 4'b0001,
    ENTRY_HOLD   = 4'b0010,
    ENTRY_TOGGLE = 4'b0100,
    ENTRY_HIGH   = 4'b1000
  } entry_t;

  // Operation chosen at a shift clock edge, one-hot
  typedef enum logic [1:0] {
    OP_LOAD  = 2'b01,
    OP_SHIFT = 2'b10
  } op_kind_t;

endpackage

// file: src/op_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module op_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16
) (
  input  wire logic               CLOCK_IN,
  input  wire logic               NRST_IN,
  input  wire logic               WR_VALID_IN,
  output logic                    WR_READY_OUT,
  input  wire logic [WIDTH-1:0]   WR_DATA_IN,
  output logic                    RD_VALID_OUT,
  input  wire logic               RD_READY_IN,
  output logic [WIDTH-1:0]        RD_DATA_OUT,
  output logic [$clog2(DEPTH):0]  LEVEL_OUT
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      wr_ptr_d;
  logic [AW:0]      rd_ptr_q;
  logic [AW:0]      rd_ptr_d;
  logic             push;
  logic             pop;

  // ****************************************************************
  // Full and empty from pointers with a wrap bit
  // ****************************************************************
  always_comb begin
    WR_READY_OUT = !((wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                     (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
    RD_VALID_OUT = (wr_ptr_q != rd_ptr_q);
    push         = WR_VALID_IN && WR_READY_OUT;
    pop          = RD_VALID_OUT && RD_READY_IN;
    wr_ptr_d     = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d     = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    RD_DATA_OUT  = mem[rd_ptr_q[AW-1:0]];
    LEVEL_OUT    = wr_ptr_q - rd_ptr_q;
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
    end
  end

  // Storage has no reset; contents are only read while valid
  always_ff @(posedge CLOCK_IN) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= WR_DATA_IN;
    end
  end
endmodule
`default_nettype wire

// file: src/four_bit_universal_shift_register.sv
`include "shift_reg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module four_bit_universal_shift_register #(
  parameter int STAGES     = `SR_STAGES,
  parameter int FIFO_DEPTH = `SR_FIFO_DEPTH
) (
  input  wire logic                      CLOCK_IN,
  input  wire logic                      NRST_IN,
  input  wire logic                      MASTER_CLEAR_N_IN,
  input  wire logic                      SHIFT_CLOCK_IN,
  input  wire logic                      OP_VALID_IN,
  output logic                           OP_READY_OUT,
  input  wire logic                      PARALLEL_LOAD_N_IN,
  input  wire logic                      SERIAL_J_IN,
  input  wire logic                      SERIAL_K_N_IN,
  input  wire logic [STAGES-1:0]         LOAD_IN,
  output logic [STAGES-1:0]              STAGE_OUT,
  output logic                           LAST_STAGE_OUT_N,
  output logic                           STEP_DONE_OUT,
  output logic                           STEP_MISS_OUT,
  output logic [$clog2(FIFO_DEPTH):0]    OP_LEVEL_OUT
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [1:0]                sclk_sync_q;
  logic [1:0]                sclk_sync_d;
  logic                      sclk_prev_q;
  logic                      sclk_prev_d;
  logic                      sclk_rise;
  logic [`SR_OP_WIDTH-1:0]   op_word_in;
  logic [`SR_OP_WIDTH-1:0]   op_word;
  logic                      op_valid;
  logic                      op_take;
  logic                      clear_n;
  logic                      clear_pin_n;
  logic [1:0]                clear_sync_q;
  logic [1:0]                clear_sync_d;
  logic [STAGES-1:0]         stage_q;
  logic [STAGES-1:0]         stage_d;
  logic                      last_n_q;
  logic                      last_n_d;
  logic                      done_q;
  logic                      done_d;
  logic                      miss_q;
  logic                      miss_d;
  logic                      first_next;
  shift_reg_pkg::entry_t     entry;
  shift_reg_pkg::op_kind_t   op_kind;

  // ****************************************************************
  // Operation queue
  // ****************************************************************
  // The surrounding logic queues each operation ahead of its shift
  // clock edge; when the queue is full, OP_READY_OUT stalls the source.
  // Offers made while the queue is full are not stored.
  always_comb begin
    op_word_in = {PARALLEL_LOAD_N_IN, SERIAL_J_IN, SERIAL_K_N_IN, LOAD_IN};
  end

  op_fifo #(
    .WIDTH (`SR_OP_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_op_fifo (
    .CLOCK_IN     (CLOCK_IN),
    .NRST_IN      (NRST_IN),
    .WR_VALID_IN  (OP_VALID_IN),
    .WR_READY_OUT (OP_READY_OUT),
    .WR_DATA_IN   (op_word_in),
    .RD_VALID_OUT (op_valid),
    .RD_READY_IN  (op_take),
    .RD_DATA_OUT  (op_word),
    .LEVEL_OUT    (OP_LEVEL_OUT)
  );

  // ****************************************************************
  // Shift clock edge detection
  // ****************************************************************
  // The shift clock is a pin: two flops before the edge detector.
  // Limitation: pin phases shorter than one system clock may be lost,
  // and a step lands two to three cycles after the pin rises.
  always_comb begin
    sclk_sync_d = {sclk_sync_q[0], SHIFT_CLOCK_IN};
    sclk_prev_d = sclk_sync_q[1];
    sclk_rise   = sclk_sync_q[1] && !sclk_prev_q;
    op_take     = sclk_rise && op_valid;
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sclk_sync_q <= `SR_SYNC_RESET;
      sclk_prev_q <= `SR_EDGE_RESET;
    end else begin
      sclk_sync_q <= sclk_sync_d;
      sclk_prev_q <= sclk_prev_d;
    end
  end

  // ****************************************************************
  // Operation decode
  // ****************************************************************
  // Low parallel-load control loads; high shifts right by one.
  always_comb begin
    if (op_word[`SR_OP_PE_BIT]) begin
      op_kind = shift_reg_pkg::OP_SHIFT;
    end else begin
      op_kind = shift_reg_pkg::OP_LOAD;
    end
    // Tying J to K-bar collapses this to plain D entry
    case ({op_word[`SR_OP_J_BIT], op_word[`SR_OP_KN_BIT]})
      2'b00:   entry = shift_reg_pkg::ENTRY_LOW;
      2'b01:   entry = shift_reg_pkg::ENTRY_HOLD;
      2'b10:   entry = shift_reg_pkg::ENTRY_TOGGLE;
      default: entry = shift_reg_pkg::ENTRY_HIGH;
    endcase
  end

  // ****************************************************************
  // First stage serial entry
  // ****************************************************************
  always_comb begin
    case (entry)
      shift_reg_pkg::ENTRY_LOW:    first_next = 1'b0;
      shift_reg_pkg::ENTRY_HOLD:   first_next = stage_q[0];
      shift_reg_pkg::ENTRY_TOGGLE: first_next = !stage_q[0];
      shift_reg_pkg::ENTRY_HIGH:   first_next = 1'b1;
      default:                     first_next = stage_q[0];
    endcase
  end

  // ****************************************************************
  // Master clear release
  // ****************************************************************
  // Master clear acts without the clock, so it joins the async reset.
  // Trade-off: the clear pin glitch-filters nothing; hold it clean.
  always_comb begin
    clear_pin_n  = NRST_IN && MASTER_CLEAR_N_IN;
    clear_sync_d = {clear_sync_q[0], 1'b1};
  end

  // Release passes two flops so no stage flop leaves reset near a
  // clock edge; the stages stay clear two cycles after the pin rises.
  always_ff @(posedge CLOCK_IN or negedge clear_pin_n) begin
    if (!clear_pin_n) begin
      clear_sync_q <= `SR_SYNC_RESET;
    end else begin
      clear_sync_q <= clear_sync_d;
    end
  end

  // ****************************************************************
  // Stage register
  // ****************************************************************
  // Assertion of the clear is immediate; only its release is timed.
  always_comb begin
    clear_n = clear_sync_q[1];
  end

  always_comb begin
    stage_d = stage_q;
    if (op_take) begin
      case (op_kind)
        shift_reg_pkg::OP_LOAD: begin
          stage_d = op_word[`SR_OP_LOAD_MSB:`SR_OP_LOAD_LSB];
        end
        shift_reg_pkg::OP_SHIFT: begin
          stage_d = {stage_q[STAGES-2:0], first_next};
        end
        default: begin
          stage_d = stage_q;
        end
      endcase
    end
    last_n_d = !stage_d[STAGES-1];
  end

  always_ff @(posedge CLOCK_IN or negedge clear_n) begin
    if (!clear_n) begin
      stage_q  <= `SR_STAGE_RESET;
      last_n_q <= `SR_LAST_RESET;
    end else begin
      stage_q  <= stage_d;
      last_n_q <= last_n_d;
    end
  end

  // ****************************************************************
  // Step status
  // ****************************************************************
  // An edge with nothing queued leaves the stages as they were.
  // Limitation: an edge taken while the clear is held still pops the
  // head word and pulses done, but the stages stay clear.
  always_comb begin
    done_d = op_take;
    miss_d = sclk_rise && !op_valid;
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      done_q <= `SR_PULSE_RESET;
      miss_q <= `SR_PULSE_RESET;
    end else begin
      done_q <= done_d;
      miss_q <= miss_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every visible stage value comes straight from a flop.
  always_comb begin
    STAGE_OUT        = stage_q;
    LAST_STAGE_OUT_N = last_n_q;
    STEP_DONE_OUT    = done_q;
    STEP_MISS_OUT    = miss_q;
  end

endmodule
`default_nettype wire

// file: test/shift_reg_props.sv
`timescale 1ns/1ns
`default_nettype none
module shift_reg_props #(
  parameter int STAGES     = 4,
  parameter int FIFO_DEPTH = 16,
  parameter int LW         = $clog2(FIFO_DEPTH)
) (
  input wire logic              CLOCK_IN,
  input wire logic              NRST_IN,
  input wire logic              MASTER_CLEAR_N_IN,
  input wire logic              SHIFT_CLOCK_IN,
  input wire logic              OP_VALID_IN,
  input wire logic              OP_READY_OUT,
  input wire logic [STAGES-1:0] STAGE_OUT,
  input wire logic              LAST_STAGE_OUT_N,
  input wire logic              STEP_DONE_OUT,
  input wire logic              STEP_MISS_OUT,
  input wire logic [LW:0]       OP_LEVEL_OUT
);
  default clocking @(posedge CLOCK_IN);
  endclocking
  default disable iff (!NRST_IN);

  chk_last_inverse: assert property (
    LAST_STAGE_OUT_N == !STAGE_OUT[3])
    else $error("inverted last stage wrong");
  chk_clear_zero: assert property (!MASTER_CLEAR_N_IN |->
    STAGE_OUT == '0) else $error("stages not cleared");
  chk_hold_idle: assert property ($changed(STAGE_OUT) |->
    STEP_DONE_OUT || !MASTER_CLEAR_N_IN) else $error("stages moved alone");
  chk_miss_hold: assert property (STEP_MISS_OUT &&
    MASTER_CLEAR_N_IN |-> $stable(STAGE_OUT))
    else $error("stages moved on miss");
  chk_step_cause: assert property (STEP_DONE_OUT || STEP_MISS_OUT |->
    $past(SHIFT_CLOCK_IN, 2) || $past(SHIFT_CLOCK_IN, 3) ||
    $past(SHIFT_CLOCK_IN, 4)) else $error("step without shift clock");
  chk_done_single: assert property (STEP_DONE_OUT |=> !STEP_DONE_OUT)
    else $error("done pulse too long");
  chk_ready_full: assert property (OP_READY_OUT ==
    (OP_LEVEL_OUT != FIFO_DEPTH)) else $error("ready disagrees with level");
  chk_level_push: assert property ($past(OP_VALID_IN && OP_READY_OUT) &&
    !STEP_DONE_OUT |-> OP_LEVEL_OUT == $past(OP_LEVEL_OUT) + 1)
    else $error("level not raised by push");
  chk_level_pop: assert property (STEP_DONE_OUT &&
    !$past(OP_VALID_IN && OP_READY_OUT) |->
    OP_LEVEL_OUT == $past(OP_LEVEL_OUT) - 1) else $error("level not cut by pop");

  cover property (STEP_DONE_OUT);
  cover property (STEP_MISS_OUT);
  cover property (!OP_READY_OUT);
  cover property (!MASTER_CLEAR_N_IN);
endmodule

bind four_bit_universal_shift_register shift_reg_props #(
  .STAGES(STAGES), .FIFO_DEPTH(FIFO_DEPTH)
) u_shift_reg_props (
  .CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN),
  .MASTER_CLEAR_N_IN(MASTER_CLEAR_N_IN), .SHIFT_CLOCK_IN(SHIFT_CLOCK_IN),
  .OP_VALID_IN(OP_VALID_IN), .OP_READY_OUT(OP_READY_OUT),
  .STAGE_OUT(STAGE_OUT), .LAST_STAGE_OUT_N(LAST_STAGE_OUT_N),
  .STEP_DONE_OUT(STEP_DONE_OUT), .STEP_MISS_OUT(STEP_MISS_OUT),
  .OP_LEVEL_OUT(OP_LEVEL_OUT)
);
`default_nettype wire

// file: test/op_source.sv
`timescale 1ns/1ns
`default_nettype none
module op_source (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       push_in,
  input  wire logic [6:0] word_in,
  input  wire logic       ready_in,
  output logic            valid_out,
  output logic [6:0]      word_out
);
  // Offer held until taken; released word is scrambled, not left stale
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      valid_out <= 1'b0;
      word_out  <= 7'h00;
    end else if (valid_out && ready_in) begin
      valid_out <= 1'b0;
      word_out  <= ~word_out;
    end else if (push_in && !valid_out) begin
      valid_out <= 1'b1;
      word_out  <= word_in;
    end
  end
endmodule
`default_nettype wire

// file: test/four_bit_universal_shift_register_tb.sv
`timescale 1ns/1ns
`default_nettype none
module four_bit_universal_shift_register_tb;
  logic        clk, rst_n, mc_n, sclk, push, vld, rdy, done, miss, last_n;
  logic [6:0]  wd, wq, w;
  logic [3:0]  st, s;
  logic [4:0]  lvl;
  logic [31:0] rs;
  logic [6:0]  q[$];
  int          i, bad_count, n_tests;

  op_source u_op_source (.clk_in(clk), .rst_n_in(rst_n), .push_in(push),
    .word_in(wd), .ready_in(rdy), .valid_out(vld), .word_out(wq));
  four_bit_universal_shift_register u_four_bit_universal_shift_register (
    .CLOCK_IN(clk), .NRST_IN(rst_n), .MASTER_CLEAR_N_IN(mc_n),
    .SHIFT_CLOCK_IN(sclk), .OP_VALID_IN(vld), .OP_READY_OUT(rdy),
    .PARALLEL_LOAD_N_IN(wq[6]), .SERIAL_J_IN(wq[5]), .SERIAL_K_N_IN(wq[4]),
    .LOAD_IN(wq[3:0]), .STAGE_OUT(st), .LAST_STAGE_OUT_N(last_n),
    .STEP_DONE_OUT(done), .STEP_MISS_OUT(miss), .OP_LEVEL_OUT(lvl));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction

  function automatic logic [3:0] nxt(logic [3:0] o, logic [6:0] c);
    logic f;
    f = c[5] ? (c[4] ? 1'b1 : ~o[0]) : (c[4] ? o[0] : 1'b0);
    return c[6] ? {o[2:0], f} : c[3:0];
  endfunction

  task automatic chk(logic [5:0] got, logic [5:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic put(logic [6:0] c, int lim);
    int k;
    push <= 1'b1;
    wd   <= c;
    @(posedge clk);
    push <= 1'b0;
    q.push_back(c);
    for (k = 0; k < lim; k++) begin
      @(posedge clk);
      if (vld !== 1'b1) break;
    end
    if (k == lim && lim > 4) begin
      chk(6'h3f, 6'h00);
      close_out();
    end
  endtask

  // Empty queue means the edge must be reported as a miss
  task automatic step();
    int   k;
    logic m;
    m = q.size() == 0;
    sclk <= 1'b1;
    repeat (3) @(posedge clk);
    sclk <= 1'b0;
    for (k = 0; k < 10; k++) begin
      @(posedge clk);
      if (done === 1'b1 || miss === 1'b1) break;
    end
    if (k == 10) begin
      chk(6'h3f, 6'h00);
      close_out();
    end
    if (!m) s = nxt(s, q.pop_front());
    chk({miss, last_n, st}, {m, ~s[3], s});
  endtask

  initial begin
    rst_n = 1'b0;
    mc_n  = 1'b1;
    sclk  = 1'b0;
    push  = 1'b0;
    wd    = 7'h00;
    s     = 4'h0;
    rs    = 32'h0000_b590;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({miss, last_n, st}, 6'h10);
    chk({rdy, lvl}, 6'h20);
    for (i = 0; i < 16; i++) begin
      rs = xs(rs);
      w  = rs[6:0];
      if (i < 5) w = {i != 0, 2'(i - 1), 4'ha};
      put(w, 40);
    end
    put(7'h2a, 4);
    chk({rdy, lvl}, 6'h10);
    $display("test fill done");
    repeat (17) step();
    step();
    chk({rdy, lvl}, 6'h20);
    $display("test drain done");
    put(7'h0f, 40);
    step();
    mc_n <= 1'b0;
    #10;
    chk({miss, last_n, st}, 6'h10);
    @(posedge clk);
    mc_n <= 1'b1;
    s = 4'h0;
    $display("test clear done");
    for (i = 0; i < 40; i++) begin
      rs = xs(rs);
      put(rs[6:0], 40);
      step();
    end
    $display("test random done");
    close_out();
  end
endmodule
`default_nettype wire
